// [logic/csbh_top.sv]
// chip-select decoding, bus hold handshake and pin-float test mode
// Function
// - bus request is an asynchronous level; it is synchronised before use
// - the device answers a request with an active-high grant
// - local bus and control float in the same cycle the grant rises
// - upper select low for memory accesses in the top 1K-256K block
// - lower select low for memory accesses in the bottom 1K-256K block
// - both edge selects low at reset release enters pin-float test mode
// - in pin-float test mode every pin floats until the next reset
// - weak pull-up on the upper select while reset is active and until the first edge after release
// - four mid selects go low within the 8K-512K mid-range window
// - enhanced mode turns mid select 0 into the coprocessor transfer request
// - enhanced mode turns mid select 3 into the numeric unit select
// - enhanced mode turns mid select 1 into the coprocessor error input
// - peripheral selects 0-4 decode in i/o space or memory space
// - peripheral select 5 is a sixth select or latched address bit 1
// - the select 5 / address 1 pin keeps driving during a grant
// - latched address bit 1 holds its last value through the grant
`timescale 1ns/1ns
module csbh_top
  import csbh_pkg::*;
#(
  parameter int unsigned ADDR_W = ADDR_BITS
) (
  // clock and reset
  input  wire logic                   core_clk,
  input  wire logic                   rstn,
  // external bus master
  input  wire logic                   bus_req_in,
  output      logic                   bus_grant_out,
  // core bus cycle
  input  wire logic                   cyc_start,
  input  wire logic                   cyc_active,
  input  wire logic                   cyc_is_mem,
  input  wire logic [ADDR_W-1:0]      cyc_addr,
  input  wire logic                   bus_idle,
  input  wire logic                   cyc_pending,
  input  wire logic                   copro_access,
  output      logic                   bus_drive_oe,
  // configuration
  input  wire logic                   enhanced_mode,
  input  wire logic [SIZE_LOG2_W-1:0] upper_size_log2,
  input  wire logic [SIZE_LOG2_W-1:0] lower_size_log2,
  input  wire logic [ADDR_W-1:0]      mid_base,
  input  wire logic [SIZE_LOG2_W-1:0] mid_size_log2,
  input  wire logic [ADDR_W-1:0]      periph_base,
  input  wire logic                   periph_in_mem,
  input  wire logic                   pcs5_is_addr1,
  // upper and lower memory select pins
  input  wire logic                   upper_mem_select_i,
  output      logic                   upper_mem_select_o,
  output      logic                   upper_mem_select_oe,
  output      logic                   upper_mem_pullup_en,
  input  wire logic                   lower_mem_select_i,
  output      logic                   lower_mem_select_o,
  output      logic                   lower_mem_select_oe,
  // mid-range select pins
  input  wire logic [MID_SELECTS-1:0] mid_mem_select_i,
  output      logic [MID_SELECTS-1:0] mid_mem_select_o,
  output      logic [MID_SELECTS-1:0] mid_mem_select_oe,
  // peripheral select pins
  output      logic [4:0]             periph_select_o,
  output      logic [4:0]             periph_select_oe,
  output      logic                   periph_select5_or_addr1_o,
  output      logic                   periph_select5_or_addr1_oe,
  // coprocessor signals toward the core
  output      logic                   copro_transfer_request,
  output      logic                   copro_numeric_error,
  // test mode status
  output      logic                   all_float_test_mode
);

  // ****************************************
  // elaboration checks
  // ****************************************
  // the decoders need room for the largest mid window and the i/o space
  if (ADDR_W < ADDR_BITS) begin : g_bad_width
    $error("csbh_top: ADDR_W below the 1 MByte address space");
  end

  // ****************************************
  // request synchroniser
  // ****************************************
  logic [SYNC_STAGES-1:0] req_sync_q;
  wire  logic             req_seen = req_sync_q[SYNC_STAGES-1];

  // only the last stage is looked at by the handshake
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      req_sync_q <= '0;
    end else begin
      req_sync_q <= {req_sync_q[SYNC_STAGES-2:0], bus_req_in};
    end
  end

  // ****************************************
  // pin-float strap capture
  // ****************************************
  logic strap_done_q;
  logic all_float_q;

  // straps are read on the first edge after release, never under reset
  wire logic strap_float = ~upper_mem_select_i & ~lower_mem_select_i;
  // the strap read happens before the first drive, so it cannot see our own low
  wire logic strap_float_pending = !strap_done_q && strap_float;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      strap_done_q <= 1'b0;
      all_float_q  <= 1'b0;
    end else begin
      strap_done_q <= 1'b1;
      if (!strap_done_q) begin
        all_float_q <= strap_float;
      end
    end
  end

  // ****************************************
  // pull-up on the upper select
  // ****************************************
  logic pullup_q;

  // released on the first edge after reset so it cannot fight a cycle
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pullup_q <= PULLUP_RST;
    end else begin
      pullup_q <= 1'b0;
    end
  end

  // ****************************************
  // hold handshake
  // ****************************************
  csbh_hold_t hold_q;
  csbh_hold_t hold_d;

  // grant only between cycles; drop it once the request has gone
  always_comb begin
    hold_d = hold_q;
    unique case (hold_q)
      CSBH_OWNED: begin
        if (req_seen && bus_idle && strap_done_q) begin
          hold_d = CSBH_GRANTED;
        end
      end
      CSBH_GRANTED: begin
        if (!req_seen) begin
          hold_d = CSBH_RELEASED;
        end
      end
      CSBH_RELEASED: begin
        if (req_seen) begin
          hold_d = CSBH_GRANTED;
        end else if (cyc_pending) begin
          hold_d = CSBH_OWNED;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      hold_q <= CSBH_OWNED;
    end else begin
      hold_q <= hold_d;
    end
  end

  // grant and bus enable are both registered from hold_d, so they move together
  wire logic grant_d = (hold_d == CSBH_GRANTED);
  wire logic owned_d = (hold_d == CSBH_OWNED) && strap_done_q && !all_float_q;
  wire logic owned   = (hold_q == CSBH_OWNED);

  // ****************************************
  // window limits
  // ****************************************
  // out-of-range sizes are clamped rather than left undefined
  wire logic [SIZE_LOG2_W-1:0] up_log2 =
    (upper_size_log2 < EDGE_MIN_LOG2) ? EDGE_MIN_LOG2 :
    (upper_size_log2 > EDGE_MAX_LOG2) ? EDGE_MAX_LOG2 : upper_size_log2;
  wire logic [SIZE_LOG2_W-1:0] lo_log2 =
    (lower_size_log2 < EDGE_MIN_LOG2) ? EDGE_MIN_LOG2 :
    (lower_size_log2 > EDGE_MAX_LOG2) ? EDGE_MAX_LOG2 : lower_size_log2;
  wire logic [SIZE_LOG2_W-1:0] mid_log2 =
    (mid_size_log2 < MID_MIN_LOG2) ? MID_MIN_LOG2 :
    (mid_size_log2 > MID_MAX_LOG2) ? MID_MAX_LOG2 : mid_size_log2;
  wire logic [SIZE_LOG2_W-1:0] mid_sub_log2 = mid_log2 - MID_SPLIT_LOG2;

  // top block starts at the space size less the block size
  wire logic [ADDR_W-1:0] all_ones = '1;
  wire logic [ADDR_W-1:0] up_base  = all_ones << up_log2;

  // ****************************************
  // address decoders
  // ****************************************
  logic                      up_hit;
  logic                      lo_hit;
  logic [MID_SELECTS-1:0]    mid_hit;
  logic [PERIPH_SELECTS-1:0] per_hit;

  csbh_range_match #(.AW(ADDR_W)) u_upper (
    .addr      (cyc_addr),
    .base      (up_base),
    .size_log2 (up_log2),
    .hit       (up_hit)
  );

  csbh_range_match #(.AW(ADDR_W)) u_lower (
    .addr      (cyc_addr),
    .base      ('0),
    .size_log2 (lo_log2),
    .hit       (lo_hit)
  );

  // each mid select covers a quarter of the mid window
  for (genvar gi = 0; gi < MID_SELECTS; gi++) begin : g_mid
    wire logic [ADDR_W-1:0] sub_base = mid_base + (ADDR_W'(gi) << mid_sub_log2);
    csbh_range_match #(.AW(ADDR_W)) u_mid (
      .addr      (cyc_addr),
      .base      (sub_base),
      .size_log2 (mid_sub_log2),
      .hit       (mid_hit[gi])
    );
  end

  // peripheral blocks follow one another from the peripheral base
  for (genvar gp = 0; gp < PERIPH_SELECTS; gp++) begin : g_per
    wire logic [ADDR_W-1:0] blk_base = periph_base + (ADDR_W'(gp) << PERIPH_BLK_LOG2);
    csbh_range_match #(.AW(ADDR_W)) u_per (
      .addr      (cyc_addr),
      .base      (blk_base),
      .size_log2 (PERIPH_BLK_LOG2),
      .hit       (per_hit[gp])
    );
  end

  // ****************************************
  // select qualification
  // ****************************************
  // selects only fire on our own cycles; a held bus keeps them all high
  wire logic live    = cyc_active && owned && !all_float_q;
  wire logic mem_cyc = live && cyc_is_mem;
  // i/o cycles must stay inside the 64 Kbyte i/o space
  wire logic io_ok   = (cyc_addr[ADDR_W-1:IO_ADDR_BITS] == '0);
  wire logic per_cyc = live && (periph_in_mem ? cyc_is_mem : (!cyc_is_mem && io_ok));

  wire logic       up_sel_d  = ~(mem_cyc && up_hit);
  wire logic       lo_sel_d  = ~(mem_cyc && lo_hit);
  wire logic [3:0] mid_sel_d = ~({MID_SELECTS{mem_cyc}} & mid_hit);
  wire logic [4:0] per_sel_d = ~({5{per_cyc}} & per_hit[4:0]);
  wire logic       per5_sel  = ~(per_cyc && per_hit[5]);

  // numeric unit select replaces the fourth mid select in enhanced mode
  wire logic       nps_d     = ~(live && copro_access);
  wire logic [3:0] mid_pin_d = enhanced_mode ? {nps_d, mid_sel_d[2:0]} : mid_sel_d;

  // mid selects 0 and 1 turn into inputs in enhanced mode
  wire logic       drive_ok  = strap_done_q && !all_float_q;
  wire logic [3:0] mid_oe_d  = {4{drive_ok}} & (enhanced_mode ? 4'h0_00C : 4'h0_00F);

  // ****************************************
  // latched address bit 1
  // ****************************************
  logic addr1_q;

  // only our own cycles update it, so a grant leaves it frozen
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      addr1_q <= 1'b0;
    end else if (cyc_start && owned) begin
      addr1_q <= cyc_addr[1];
    end
  end

  wire logic addr1_d = (cyc_start && owned) ? cyc_addr[1] : addr1_q;
  wire logic pcs5_d  = pcs5_is_addr1 ? addr1_d : per5_sel;

  // ****************************************
  // pin registers
  // ****************************************
  logic             grant_q;
  logic             bus_oe_q;
  logic             up_o_q;
  logic             lo_o_q;
  logic             edge_oe_q;
  logic [3:0]       mid_o_q;
  logic [3:0]       mid_oe_q;
  logic [4:0]       per_o_q;
  logic             pcs5_o_q;
  logic             pcs5_oe_q;
  logic             copro_transfer_request_q;
  logic             nerr_q;

  // chip selects float in reset, up to the second edge after release and in test mode, otherwise always driven
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      grant_q   <= GRANT_RST;
      bus_oe_q  <= 1'b0;
      up_o_q    <= SEL_IDLE;
      lo_o_q    <= SEL_IDLE;
      edge_oe_q <= 1'b0;
      mid_o_q   <= {MID_SELECTS{SEL_IDLE}};
      mid_oe_q  <= '0;
      per_o_q   <= {5{SEL_IDLE}};
      pcs5_o_q  <= SEL_IDLE;
      pcs5_oe_q <= 1'b0;
    end else begin
      grant_q   <= grant_d && drive_ok;
      bus_oe_q  <= owned_d && !(grant_d && drive_ok);
      up_o_q    <= up_sel_d;
      lo_o_q    <= lo_sel_d;
      edge_oe_q <= drive_ok && !strap_float_pending;
      mid_o_q   <= mid_pin_d;
      mid_oe_q  <= mid_oe_d;
      per_o_q   <= per_sel_d;
      pcs5_o_q  <= pcs5_d;
      pcs5_oe_q <= drive_ok;
    end
  end

  // ****************************************
  // coprocessor inputs
  // ****************************************
  // pins are taken as synchronous; qualified by mode so idle selects read low
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      copro_transfer_request_q <= 1'b0;
      nerr_q  <= 1'b0;
    end else begin
      copro_transfer_request_q <= enhanced_mode && mid_mem_select_i[0];
      nerr_q  <= enhanced_mode && mid_mem_select_i[1];
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign bus_grant_out              = grant_q;
  assign bus_drive_oe               = bus_oe_q;
  assign upper_mem_select_o         = up_o_q;
  assign upper_mem_select_oe        = edge_oe_q;
  assign upper_mem_pullup_en        = pullup_q;
  assign lower_mem_select_o         = lo_o_q;
  assign lower_mem_select_oe        = edge_oe_q;
  assign mid_mem_select_o           = mid_o_q;
  assign mid_mem_select_oe          = mid_oe_q;
  assign periph_select_o            = per_o_q;
  assign periph_select_oe           = {5{edge_oe_q}};
  assign periph_select5_or_addr1_o  = pcs5_o_q;
  assign periph_select5_or_addr1_oe = pcs5_oe_q;
  assign copro_transfer_request     = copro_transfer_request_q;
  assign copro_numeric_error        = nerr_q;
  assign all_float_test_mode        = all_float_q;

  // ****************************************
  // checks
  // ****************************************
  a_req_synced: assert property (@(posedge core_clk) disable iff (!rstn)
    $rose(bus_grant_out) |-> $past(bus_req_in, 3))
    else $error("grant rose without a synchronised request");

  a_grant_float: assert property (@(posedge core_clk) disable iff (!rstn)
    bus_grant_out |-> !bus_drive_oe)
    else $error("bus driven while grant is high");

  a_sel_held: assert property (@(posedge core_clk) disable iff (!rstn)
    bus_grant_out |-> (upper_mem_select_o && lower_mem_select_o && (&periph_select_o)))
    else $error("chip select active during grant");

  a_grant_drop: assert property (@(posedge core_clk) disable iff (!rstn)
    (bus_grant_out && !req_seen) |=> !bus_grant_out)
    else $error("grant not dropped after request fell");

  a_float_all: assert property (@(posedge core_clk) disable iff (!rstn)
    all_float_test_mode |-> !(upper_mem_select_oe || bus_drive_oe || pcs5_oe_q || (|mid_oe_q)))
    else $error("pin driven in float test mode");

  a_float_keep: assert property (@(posedge core_clk) disable iff (!rstn)
    (strap_done_q && $past(all_float_test_mode)) |-> all_float_test_mode)
    else $error("float test mode left without reset");

  a_pcs5_drive: assert property (@(posedge core_clk) disable iff (!rstn)
    (bus_grant_out && !all_float_test_mode) |-> periph_select5_or_addr1_oe)
    else $error("select 5 pin floated during grant");

  a_addr1_hold: assert property (@(posedge core_clk) disable iff (!rstn)
    (bus_grant_out && $past(bus_grant_out) && pcs5_is_addr1 && $past(pcs5_is_addr1))
      |-> $stable(periph_select5_or_addr1_o))
    else $error("latched address bit 1 changed during grant");

  a_upper_hit: assert property (@(posedge core_clk) disable iff (!rstn)
    (mem_cyc && up_hit) |=> !upper_mem_select_o)
    else $error("upper select missed a top-block access");

  a_lower_hit: assert property (@(posedge core_clk) disable iff (!rstn)
    (mem_cyc && lo_hit) |=> !lower_mem_select_o)
    else $error("lower select missed a bottom-block access");

  a_pullup_off: assert property (@(posedge core_clk) disable iff (!rstn)
    strap_done_q |-> !upper_mem_pullup_en)
    else $error("upper pull-up left on after reset");

  a_nps_only: assert property (@(posedge core_clk) disable iff (!rstn)
    (enhanced_mode && $past(enhanced_mode) && !mid_mem_select_o[3]) |-> $past(copro_access))
    else $error("numeric unit select without coprocessor access");

endmodule : csbh_top

// [logic/csbh_pkg.sv]
// shared constants for the chip-select and bus-hold block
package csbh_pkg;

  // ****************************************
  // address space
  // ****************************************
  localparam int unsigned ADDR_BITS       = 20;  // 1 MByte memory space
  localparam int unsigned IO_ADDR_BITS    = 16;  // 64 Kbyte i/o space
  localparam int unsigned SIZE_LOG2_W     = 5;   // width of a block-size exponent

  // ****************************************
  // window size limits, as log2 of bytes
  // ****************************************
  localparam logic [4:0]  EDGE_MIN_LOG2   = 5'h0_00A;  // upper/lower block 1K
  localparam logic [4:0]  EDGE_MAX_LOG2   = 5'h0_012;  // upper/lower block 256K
  localparam logic [4:0]  MID_MIN_LOG2    = 5'h0_00D;  // mid-range total 8K
  localparam logic [4:0]  MID_MAX_LOG2    = 5'h0_013;  // mid-range total 512K
  localparam logic [4:0]  MID_SPLIT_LOG2  = 5'h0_002;  // four equal mid sub-blocks
  localparam logic [4:0]  PERIPH_BLK_LOG2 = 5'h0_007;  // 128 bytes per peripheral select

  // ****************************************
  // select counts
  // ****************************************
  localparam int unsigned MID_SELECTS     = 4;
  localparam int unsigned PERIPH_SELECTS  = 6;  // five plain plus the shared sixth pin

  // ****************************************
  // reset values
  // ****************************************
  localparam logic        SEL_IDLE        = 1'b1;  // chip selects are active low
  localparam logic        GRANT_RST       = 1'b0;
  localparam logic        PULLUP_RST      = 1'b1;

  // ****************************************
  // request synchroniser depth
  // ****************************************
  localparam int unsigned SYNC_STAGES     = 2;

  // hold handshake states
  typedef enum logic [1:0] {
    CSBH_OWNED,     // device drives the local bus
    CSBH_GRANTED,   // another master owns the bus
    CSBH_RELEASED   // grant dropped, bus still floated until a cycle is needed
  } csbh_hold_t;

endpackage : csbh_pkg

// [logic/csbh_range_match.sv]
// address window compare for one chip select
`timescale 1ns/1ns
module csbh_range_match
  import csbh_pkg::*;
#(
  parameter int unsigned AW = ADDR_BITS
) (
  // address under test
  input  wire logic [AW-1:0]          addr,
  // window start, aligned to its size
  input  wire logic [AW-1:0]          base,
  input  wire logic [SIZE_LOG2_W-1:0] size_log2,
  // match result
  output      logic                   hit
);

  // ****************************************
  // compare
  // ****************************************
  // aligned windows only need the bits above the size to agree
  wire logic [AW-1:0] diff_bits = addr ^ base;
  wire logic [AW-1:0] above     = diff_bits >> size_log2;

  assign hit = (above == '0);

endmodule : csbh_range_match

// [dv/csbh_partner.sv]
// board-side model: strap resistors, pin pull-ups, coprocessor and the other bus master
`timescale 1ns/1ns
module csbh_partner (
  // pins driven by the block
  input  wire logic       upper_o,
  input  wire logic       upper_oe,
  input  wire logic       lower_o,
  input  wire logic       lower_oe,
  input  wire logic [3:0] mid_o,
  input  wire logic [3:0] mid_oe,
  // board and coprocessor controls from the bench
  input  wire logic       enhanced,
  input  wire logic       strap_up,
  input  wire logic       strap_lo,
  input  wire logic       copro_req,
  input  wire logic       copro_err,
  input  wire logic       want_bus,
  input  wire logic       refresh_due,
  // resolved levels back to the block
  output      logic       upper_i,
  output      logic       lower_i,
  output      logic [3:0] mid_i,
  output      logic       bus_req
);
  // a strap resistor beats the weak pull-up; released pins settle to the board pull-up
  assign upper_i = upper_oe ? upper_o : ~strap_up;
  assign lower_i = lower_oe ? lower_o : ~strap_lo;
  // coprocessor owns mid lines 0 and 1 once they turn into inputs
  assign mid_i[0] = mid_oe[0] ? mid_o[0] : (enhanced ? copro_req : 1'b1);
  assign mid_i[1] = mid_oe[1] ? mid_o[1] : (enhanced ? copro_err : 1'b1);
  assign mid_i[3:2] = mid_o[3:2] | ~mid_oe[3:2];
  // in enhanced mode the other master gives the bus back when a refresh is waiting
  assign bus_req = want_bus & ~(enhanced & refresh_due);
endmodule : csbh_partner

// [dv/csbh_top_tb_top.sv]
// self-checking bench for the chip-select and bus-hold block
`timescale 1ns/1ns
module csbh_top_tb_top import csbh_pkg::*; ;
  logic core_clk, rstn, bus_req_in, bus_grant_out, cyc_start, cyc_active, cyc_is_mem;
  logic bus_idle, cyc_pending, copro_access, bus_drive_oe, enhanced_mode, periph_in_mem;
  logic pcs5_is_addr1, upper_mem_select_i, upper_mem_select_o, upper_mem_select_oe;
  logic upper_mem_pullup_en, lower_mem_select_i, lower_mem_select_o, lower_mem_select_oe;
  logic periph_select5_or_addr1_o, periph_select5_or_addr1_oe, copro_transfer_request;
  logic copro_numeric_error, all_float_test_mode, want_bus, refresh_due;
  logic strap_up, strap_lo, copro_req, copro_err;
  logic [19:0] cyc_addr, mid_base, periph_base;
  logic [4:0]  upper_size_log2, lower_size_log2, mid_size_log2, periph_select_o, periph_select_oe;
  logic [3:0]  mid_mem_select_i, mid_mem_select_o, mid_mem_select_oe;
  int          num_errors = 0;
  int          check_count = 0;
  int          a, n;
  // active-high view of every select: bit0 upper, 1 lower, 2-5 mid, 6-11 peripheral
  wire logic [11:0] sel_hits = ~{periph_select5_or_addr1_o, periph_select_o,
                                 mid_mem_select_o, lower_mem_select_o, upper_mem_select_o};

  csbh_top i_csbh_top (.core_clk, .rstn, .bus_req_in, .bus_grant_out, .cyc_start,
    .cyc_active, .cyc_is_mem, .cyc_addr, .bus_idle, .cyc_pending, .copro_access,
    .bus_drive_oe, .enhanced_mode, .upper_size_log2, .lower_size_log2, .mid_base,
    .mid_size_log2, .periph_base, .periph_in_mem, .pcs5_is_addr1, .upper_mem_select_i,
    .upper_mem_select_o, .upper_mem_select_oe, .upper_mem_pullup_en, .lower_mem_select_i,
    .lower_mem_select_o, .lower_mem_select_oe, .mid_mem_select_i, .mid_mem_select_o,
    .mid_mem_select_oe, .periph_select_o, .periph_select_oe, .periph_select5_or_addr1_o,
    .periph_select5_or_addr1_oe, .copro_transfer_request, .copro_numeric_error,
    .all_float_test_mode);
  csbh_partner i_csbh_partner (.upper_o(upper_mem_select_o), .upper_oe(upper_mem_select_oe),
    .lower_o(lower_mem_select_o), .lower_oe(lower_mem_select_oe), .mid_o(mid_mem_select_o),
    .mid_oe(mid_mem_select_oe), .enhanced(enhanced_mode), .strap_up, .strap_lo, .copro_req,
    .copro_err, .want_bus, .refresh_due, .upper_i(upper_mem_select_i),
    .lower_i(lower_mem_select_i), .mid_i(mid_mem_select_i), .bus_req(bus_req_in));

  // ****************************************
  // clock, checks and reference model
  // ****************************************
  always #5 core_clk = ~core_clk;

  task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // windows are disjoint here, so each select is worked out on its own
  function automatic logic [11:0] model(input int ad, input bit mem);
    logic [11:0] h;
    int          ms;
    int          q;
    h = '0;
    ms = mid_size_log2;
    q = ad - periph_base;
    if (mem && ad >= (1 << 20) - (1 << upper_size_log2)) h[0] = 1'b1;
    if (mem && ad < (1 << lower_size_log2)) h[1] = 1'b1;
    if (mem && ad >= mid_base && ad < mid_base + (1 << ms)) h[2 + ((ad - mid_base) >> (ms - 2))] = 1'b1;
    if (mem == periph_in_mem && (mem || ad < 'h10000) && q >= 0 && q < 768) h[6 + q / 128] = 1'b1;
    return h;
  endfunction : model

  task automatic do_reset(input logic [4:0] exp_after);
    rstn = 1'b0;
    repeat (20) @(posedge core_clk);
    #1;
    chk(12'({bus_grant_out, upper_mem_pullup_en, upper_mem_select_oe, bus_drive_oe}), 12'h0_004, "in reset");
    rstn = 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    chk(12'({upper_mem_pullup_en, all_float_test_mode, upper_mem_select_oe, lower_mem_select_oe,
             bus_drive_oe}), 12'(exp_after), "after reset");
  endtask : do_reset

  task automatic step;
    @(posedge core_clk);
    #1;
  endtask : step

  task automatic final_report;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    core_clk = 0; rstn = 0; cyc_start = 0; cyc_active = 0; cyc_is_mem = 1; cyc_addr = '0;
    bus_idle = 1; cyc_pending = 0; copro_access = 0; enhanced_mode = 0; periph_in_mem = 0;
    pcs5_is_addr1 = 0; upper_size_log2 = 5'h0_00A; lower_size_log2 = 5'h0_00A;
    mid_base = 20'h4_0000; mid_size_log2 = 5'h0_00D; periph_base = 20'h0_0400;
    want_bus = 0; refresh_due = 0; strap_up = 0; strap_lo = 0; copro_req = 0; copro_err = 0;
    void'($urandom(23));
    do_reset(5'h07);
    // random windows, addresses near every boundary but the peripheral end, both peripheral spaces
    cyc_active = 1;
    for (int k = 0; k < 2; k++) begin
      periph_in_mem = k[0];
      periph_base = k[0] ? 20'h8_0400 : 20'h0_0400;
      for (n = 0; n < 60; n++) begin
        upper_size_log2 = 5'(10 + $urandom % 9);
        lower_size_log2 = 5'(10 + $urandom % 9);
        mid_size_log2 = 5'(13 + $urandom % 6);
        case ($urandom % 5)
          0: a = (1 << 20) - (1 << upper_size_log2);
          1: a = 1 << lower_size_log2;
          2: a = mid_base;
          3: a = mid_base + (1 << mid_size_log2);
          default: a = periph_base;
        endcase
        a = (a + int'($urandom % 1024) - 512) & 'hF_FFFF;
        cyc_addr = 20'(a);
        cyc_is_mem = 1'($urandom % 2);
        step();
        chk(sel_hits, model(a, cyc_is_mem), "select decode");
      end
    end
    // latched address bit 1, then the hold handshake with it held
    pcs5_is_addr1 = 1; cyc_active = 0; cyc_start = 1; cyc_addr = 20'h0_0002;
    step();
    cyc_start = 0;
    enhanced_mode = 1;
    want_bus = 1;
    step();
    chk(12'(periph_select5_or_addr1_o), 12'h0_001, "addr1 latch");
    step();
    chk(12'(bus_grant_out), 12'h0_000, "grant early");
    step();
    chk(12'({bus_grant_out, bus_drive_oe, periph_select5_or_addr1_o, periph_select5_or_addr1_oe}),
        12'h0_00B, "grant");
    cyc_active = 1; cyc_is_mem = 1; cyc_start = 1; cyc_addr = 20'hF_FFF0;
    step();
    cyc_start = 0;
    step();
    chk(sel_hits, 12'h0_000, "held selects");
    cyc_active = 0;
    refresh_due = 1;
    repeat (2) step();
    chk(12'(bus_grant_out), 12'h0_001, "grant stands");
    step();
    chk(12'({bus_grant_out, bus_drive_oe}), 12'h0_000, "grant drop");
    want_bus = 0;
    refresh_due = 0;
    repeat (3) step();
    chk(12'(bus_drive_oe), 12'h0_000, "stay floated");
    cyc_pending = 1;
    step();
    chk(12'(bus_drive_oe), 12'h0_001, "resume");
    // coprocessor lines in enhanced mode; the numeric select needs a live cycle
    cyc_active = 1;
    for (int k = 0; k < 6; k++) begin
      copro_req = 1'($urandom % 2);
      copro_err = 1'($urandom % 2);
      copro_access = k[0];
      step();
      chk(12'({copro_transfer_request, copro_numeric_error, mid_mem_select_oe[1:0],
               mid_mem_select_o[3]}), 12'({copro_req, copro_err, 2'b00, ~k[0]}), "copro");
    end
    // both straps low: everything floats and no grant is given
    copro_access = 0; strap_up = 1; strap_lo = 1;
    do_reset(5'h08);
    want_bus = 1;
    repeat (6) step();
    chk(12'({bus_grant_out, |mid_mem_select_oe, |periph_select_oe, periph_select5_or_addr1_oe}),
        12'h0_000, "float pins");
    want_bus = 0;
    strap_up = 0;
    do_reset(5'h07);
    final_report();
  end

  // cut a hang short well past the expected few hundred cycles
  initial begin
    #50_000;
    num_errors++;
    $display("BAD %0t watchdog expired", $time);
    final_report();
  end
endmodule : csbh_top_tb_top
